// *** src/status_pkg.sv ***
/*
 * Shared constants, command codes and carrier types of the status
 * reporting hierarchy.
 * Assumes one system clock and a remote command port in front of it.
 */
package status_pkg;
	localparam int PART_W   = 15;
	localparam int REG_W    = 16;
	localparam int STB_W    = 8;
	localparam int ESR_W    = 8;
	localparam int QUES_POWER_BIT = 9;
	localparam int STB_ERRQ = 2;
	localparam int STB_QUES = 3;
	localparam int STB_MAV  = 4;
	localparam int STB_ESB  = 5;
	localparam int STB_MSS  = 6;
	localparam int STB_OPER = 7;
	localparam int ERRQ_DEPTH = 4;
	localparam int ERRQ_AW    = 2;
	localparam logic [ERRQ_AW:0]   ERRQ_FULL  = 3'h4;
	localparam logic [PART_W-1:0]  RISE_RST   = 15'h7FFF;
	localparam logic [PART_W-1:0]  FALL_RST   = 15'h0000;
	localparam logic [PART_W-1:0]  MASK_RST   = 15'h0000;
	localparam logic [ESR_W-1:0]   ESE_RST    = 8'h00;
	localparam logic [STB_W-1:0]   SRE_RST    = 8'h00;
	localparam logic [STB_W-1:0]   SRE_IGNORE = 8'h40;

	typedef enum logic [2:0] {
		TGT_OPER  = 3'h0,
		TGT_QUES  = 3'h1,
		TGT_ESR   = 3'h2,
		TGT_STB   = 3'h3,
		TGT_SRE   = 3'h4,
		TGT_ERRQ  = 3'h5,
		TGT_CLEAR = 3'h6
	} target_type;

	typedef enum logic [2:0] {
		PART_COND  = 3'h0,
		PART_RISE  = 3'h1,
		PART_FALL  = 3'h2,
		PART_EVENT = 3'h3,
		PART_MASK  = 3'h4
	} part_type;

	typedef struct packed {
		logic             valid;
		logic             write;
		target_type       target;
		part_type         part;
		logic [REG_W-1:0] wdata;
	} cmd_type;

	typedef struct packed {
		logic             valid;
		logic [REG_W-1:0] data;
	} rsp_type;

	typedef struct packed {
		logic              push;
		logic [PART_W-1:0] code;
	} err_type;
endpackage : status_pkg

// *** src/status_register.sv ***
/*
 * One five-part status register: condition, rise filter, fall filter,
 * clear-on-read event latch and summary mask, with its sum bit.
 * Assumes sel and cmd come from the top decode; read data is combinational.
 */
`timescale 1ns/1ps
`default_nettype none
module status_register (
	input  wire logic                           ref_clk,
	input  wire logic                           rstn,
	input  wire logic                           clear,
	input  wire logic                           sel,
	input  wire status_pkg::cmd_type            cmd,
	input  wire logic [status_pkg::PART_W-1:0]  cond_in,
	output logic      [status_pkg::REG_W-1:0]   rd_data,
	output logic                                sum_bit
);
	logic [status_pkg::PART_W-1:0] hist_ff;
	logic [status_pkg::PART_W-1:0] rise_ff;
	logic [status_pkg::PART_W-1:0] fall_ff;
	logic [status_pkg::PART_W-1:0] event_ff;
	logic [status_pkg::PART_W-1:0] mask_ff;
	logic [status_pkg::PART_W-1:0] nxt_event;
	logic [status_pkg::PART_W-1:0] rise_hit;
	logic [status_pkg::PART_W-1:0] fall_hit;
	logic                          wr;
	logic                          ev_rd;

	assign wr    = sel & cmd.valid & cmd.write;
	assign ev_rd = sel & cmd.valid & ~cmd.write & (cmd.part == status_pkg::PART_EVENT);

	genvar i;
	for (i = 0; i < status_pkg::PART_W; i++) begin : g_bit
		assign rise_hit[i]  = ~hist_ff[i] & cond_in[i] & rise_ff[i];
		assign fall_hit[i]  = hist_ff[i] & ~cond_in[i] & fall_ff[i];
		// A filtered edge wins over the read clear
		assign nxt_event[i] = (event_ff[i] & ~ev_rd) | rise_hit[i] | fall_hit[i];
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			hist_ff  <= '0;
			event_ff <= '0;
		end else if (clear) begin
			hist_ff  <= '0;
			event_ff <= '0;
		end else begin
			hist_ff  <= cond_in;
			event_ff <= nxt_event;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rise_ff <= status_pkg::RISE_RST;
			fall_ff <= status_pkg::FALL_RST;
			mask_ff <= status_pkg::MASK_RST;
		end else if (wr) begin
			// Condition and event writes fall through untouched
			unique case (cmd.part)
				status_pkg::PART_RISE: rise_ff <= cmd.wdata[status_pkg::PART_W-1:0];
				status_pkg::PART_FALL: fall_ff <= cmd.wdata[status_pkg::PART_W-1:0];
				status_pkg::PART_MASK: mask_ff <= cmd.wdata[status_pkg::PART_W-1:0];
				default: ;
			endcase
		end
	end

	always_comb begin
		unique case (cmd.part)
			status_pkg::PART_COND:  rd_data = {1'b0, cond_in};
			status_pkg::PART_RISE:  rd_data = {1'b0, rise_ff};
			status_pkg::PART_FALL:  rd_data = {1'b0, fall_ff};
			status_pkg::PART_EVENT: rd_data = {1'b0, event_ff};
			status_pkg::PART_MASK:  rd_data = {1'b0, mask_ff};
			default:                rd_data = '0;
		endcase
	end

	assign sum_bit = |(event_ff & mask_ff);

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	property p_rise_sets;
		!clear && (rise_hit != '0) |=> ((event_ff & $past(rise_hit)) == $past(rise_hit));
	endproperty
	a_rise_sets: assert property (p_rise_sets) else $error("rise edge lost");

	property p_fall_sets;
		!clear && (fall_hit != '0) |=> ((event_ff & $past(fall_hit)) == $past(fall_hit));
	endproperty
	a_fall_sets: assert property (p_fall_sets) else $error("fall edge lost");

	property p_event_holds;
		!ev_rd && !clear |=> ((event_ff & $past(event_ff)) == $past(event_ff));
	endproperty
	a_event_holds: assert property (p_event_holds) else $error("event dropped early");

	sequence s_quiet_read;
		ev_rd && !clear && (rise_hit == '0) && (fall_hit == '0);
	endsequence
	property p_read_clears;
		s_quiet_read |=> (event_ff == '0);
	endproperty
	a_read_clears: assert property (p_read_clears) else $error("event not cleared");

	property p_set_wins;
		ev_rd && !clear && (rise_hit != '0) |=> (event_ff != '0);
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("event lost on read");
endmodule : status_register
`default_nettype wire

// *** src/status_reporting_hierarchy.sv ***
/*
 * Status reporting hierarchy: operation and questionable registers,
 * standard event register, error queue, status byte, service request.
 * Assumes one remote command per cycle at most; answers one cycle later.
 */
`timescale 1ns/1ps
`default_nettype none
module status_reporting_hierarchy (
	input  wire logic                           ref_clk,
	input  wire logic                           rstn,
	input  wire status_pkg::cmd_type            cmd,
	input  wire logic [status_pkg::PART_W-1:0]  oper_src,
	input  wire logic [status_pkg::PART_W-1:0]  ques_src,
	input  wire logic                           power_status,
	input  wire logic [status_pkg::ESR_W-1:0]   std_events,
	input  wire logic                           out_buf_not_empty,
	input  wire status_pkg::err_type            err,
	output status_pkg::rsp_type                 rsp_ff,
	output logic      [status_pkg::STB_W-1:0]   stb_ff,
	output logic                                srq_ff
);
	logic [status_pkg::PART_W-1:0]  ques_cond;
	logic [status_pkg::REG_W-1:0]   oper_rd;
	logic [status_pkg::REG_W-1:0]   ques_rd;
	logic [status_pkg::REG_W-1:0]   esr_rd;
	logic                           oper_sum;
	logic                           ques_sum;
	logic                           esr_sum;
	logic                           clear_cmd;
	logic                           rd_cmd;
	logic [status_pkg::STB_W-1:0]   sre_ff;
	logic [status_pkg::STB_W-1:0]   sre_eff;
	logic [status_pkg::STB_W-1:0]   stb_low;
	logic [status_pkg::STB_W-1:0]   nxt_stb;
	logic                           mss;
	logic [status_pkg::PART_W-1:0]  errq_mem_ff [status_pkg::ERRQ_DEPTH];
	logic [status_pkg::ERRQ_AW-1:0] wr_ptr_ff;
	logic [status_pkg::ERRQ_AW-1:0] rd_ptr_ff;
	logic [status_pkg::ERRQ_AW:0]   errq_cnt_ff;
	logic                           errq_push;
	logic                           errq_pop;
	logic [status_pkg::REG_W-1:0]   nxt_rsp_data;

	assign clear_cmd = cmd.valid & cmd.write & (cmd.target == status_pkg::TGT_CLEAR);
	assign rd_cmd    = cmd.valid & ~cmd.write;

	// Power status owns bit nine of the questionable condition
	always_comb begin
		ques_cond = ques_src;
		ques_cond[status_pkg::QUES_POWER_BIT] = power_status;
	end

	status_register u_oper (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.clear   (clear_cmd),
		.sel     (cmd.target == status_pkg::TGT_OPER),
		.cmd     (cmd),
		.cond_in (oper_src),
		.rd_data (oper_rd),
		.sum_bit (oper_sum)
	);

	status_register u_ques (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.clear   (clear_cmd),
		.sel     (cmd.target == status_pkg::TGT_QUES),
		.cmd     (cmd),
		.cond_in (ques_cond),
		.rd_data (ques_rd),
		.sum_bit (ques_sum)
	);

	std_event_latch u_esr (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.clear   (clear_cmd),
		.sel     (cmd.target == status_pkg::TGT_ESR),
		.cmd     (cmd),
		.set_in  (std_events),
		.rd_data (esr_rd),
		.sum_bit (esr_sum)
	);

	// Error queue; a full queue drops the newest entry, keeping the oldest
	assign errq_push = err.push & (errq_cnt_ff != status_pkg::ERRQ_FULL);
	assign errq_pop  = rd_cmd & (cmd.target == status_pkg::TGT_ERRQ) & (errq_cnt_ff != '0);

	always_ff @(posedge ref_clk) begin
		if (errq_push) begin
			errq_mem_ff[wr_ptr_ff] <= err.code;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			wr_ptr_ff   <= '0;
			rd_ptr_ff   <= '0;
			errq_cnt_ff <= '0;
		end else if (clear_cmd) begin
			wr_ptr_ff   <= '0;
			rd_ptr_ff   <= '0;
			errq_cnt_ff <= '0;
		end else begin
			if (errq_push) begin
				wr_ptr_ff <= wr_ptr_ff + 2'h1;
			end
			if (errq_pop) begin
				rd_ptr_ff <= rd_ptr_ff + 2'h1;
			end
			unique case ({errq_push, errq_pop})
				2'b10:   errq_cnt_ff <= errq_cnt_ff + 3'h1;
				2'b01:   errq_cnt_ff <= errq_cnt_ff - 3'h1;
				default: errq_cnt_ff <= errq_cnt_ff;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			sre_ff <= status_pkg::SRE_RST;
		end else if (cmd.valid && cmd.write && cmd.target == status_pkg::TGT_SRE) begin
			sre_ff <= cmd.wdata[status_pkg::STB_W-1:0];
		end
	end

	assign sre_eff = sre_ff & ~status_pkg::SRE_IGNORE;

	// Status byte is the condition part of the top level
	always_comb begin
		stb_low = '0;
		stb_low[status_pkg::STB_ERRQ] = (errq_cnt_ff != '0);
		stb_low[status_pkg::STB_QUES] = ques_sum;
		stb_low[status_pkg::STB_MAV]  = out_buf_not_empty;
		stb_low[status_pkg::STB_ESB]  = esr_sum;
		stb_low[status_pkg::STB_OPER] = oper_sum;
	end

	assign mss = |(stb_low & sre_eff);

	always_comb begin
		nxt_stb = stb_low;
		nxt_stb[status_pkg::STB_MSS] = mss;
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			stb_ff <= '0;
			srq_ff <= 1'b0;
		end else begin
			stb_ff <= nxt_stb;
			srq_ff <= |(nxt_stb & ~stb_ff & sre_eff);
		end
	end

	always_comb begin
		unique case (cmd.target)
			status_pkg::TGT_OPER: nxt_rsp_data = oper_rd;
			status_pkg::TGT_QUES: nxt_rsp_data = ques_rd;
			status_pkg::TGT_ESR:  nxt_rsp_data = esr_rd;
			status_pkg::TGT_STB:  nxt_rsp_data = {8'h00, stb_ff};
			status_pkg::TGT_SRE:  nxt_rsp_data = {8'h00, sre_ff};
			status_pkg::TGT_ERRQ: begin
				nxt_rsp_data = (errq_cnt_ff != '0) ? {1'b0, errq_mem_ff[rd_ptr_ff]} : '0;
			end
			default:              nxt_rsp_data = '0;
		endcase
	end

	// Every read answers exactly one cycle later
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rsp_ff <= '0;
		end else begin
			rsp_ff.valid <= rd_cmd;
			rsp_ff.data  <= rd_cmd ? nxt_rsp_data : '0;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	sequence s_read;
		cmd.valid && !cmd.write;
	endsequence
	property p_read_answer;
		s_read |=> rsp_ff.valid;
	endproperty
	a_read_answer: assert property (p_read_answer) else $error("read not answered");

	property p_bit15_zero;
		rsp_ff.valid |-> !rsp_ff.data[status_pkg::REG_W-1];
	endproperty
	a_bit15_zero: assert property (p_bit15_zero) else $error("bit 15 read as one");

	property p_mav;
		out_buf_not_empty |=> stb_ff[status_pkg::STB_MAV];
	endproperty
	a_mav: assert property (p_mav) else $error("message bit not set");

	property p_errq_bit;
		// Count lands one edge after the push, the status byte one edge later
		err.push && !clear_cmd |=> ##1 stb_ff[status_pkg::STB_ERRQ];
	endproperty
	a_errq_bit: assert property (p_errq_bit) else $error("error queue bit missing");

	property p_ques_up;
		ques_sum |=> stb_ff[status_pkg::STB_QUES];
	endproperty
	a_ques_up: assert property (p_ques_up) else $error("ques sum not in status byte");

	property p_srq_cause;
		srq_ff |-> stb_ff[status_pkg::STB_MSS]
			&& ((stb_ff & ~$past(stb_ff) & $past(sre_eff)) != '0);
	endproperty
	a_srq_cause: assert property (p_srq_cause) else $error("request without cause");

	sequence s_power_event;
		rd_cmd && (cmd.target == status_pkg::TGT_QUES)
			&& (cmd.part == status_pkg::PART_COND);
	endsequence
	property p_power_seen;
		s_power_event |=> rsp_ff.data[status_pkg::QUES_POWER_BIT] == $past(power_status);
	endproperty
	a_power_seen: assert property (p_power_seen) else $error("power bit not in condition");

	property p_mss_ignores_sre6;
		$past(sre_ff) == sre_ff && $past(stb_low) == stb_low
			|-> stb_ff[status_pkg::STB_MSS] == |(stb_low & sre_ff & ~status_pkg::SRE_IGNORE);
	endproperty
	a_mss_ignores_sre6: assert property (p_mss_ignores_sre6) else $error("master bit wrong");

	property p_errq_bound;
		errq_cnt_ff <= status_pkg::ERRQ_FULL;
	endproperty
	a_errq_bound: assert property (p_errq_bound) else $error("error queue overfilled");

	property p_errq_pop;
		errq_pop && !errq_push && !clear_cmd |=> errq_cnt_ff == $past(errq_cnt_ff) - 3'h1;
	endproperty
	a_errq_pop: assert property (p_errq_pop) else $error("pop did not shrink queue");

	property p_clear_errq;
		clear_cmd |=> errq_cnt_ff == '0;
	endproperty
	a_clear_errq: assert property (p_clear_errq) else $error("clear left queue entries");

	property p_errq_empty_bit;
		errq_cnt_ff == '0 |=> !stb_ff[status_pkg::STB_ERRQ];
	endproperty
	a_errq_empty_bit: assert property (p_errq_empty_bit) else $error("error bit on empty queue");

	property p_rsp_idle;
		!rsp_ff.valid |-> rsp_ff.data == '0;
	endproperty
	a_rsp_idle: assert property (p_rsp_idle) else $error("answer data without valid");

	property p_stb_unused;
		stb_ff[status_pkg::STB_ERRQ-1:0] == '0;
	endproperty
	a_stb_unused: assert property (p_stb_unused) else $error("unused status bits set");

	property p_mav_low;
		!out_buf_not_empty |=> !stb_ff[status_pkg::STB_MAV];
	endproperty
	a_mav_low: assert property (p_mav_low) else $error("message bit without message");

	property p_esb_up;
		esr_sum |=> stb_ff[status_pkg::STB_ESB];
	endproperty
	a_esb_up: assert property (p_esb_up) else $error("esr sum not in status byte");

	property p_oper_up;
		oper_sum |=> stb_ff[status_pkg::STB_OPER];
	endproperty
	a_oper_up: assert property (p_oper_up) else $error("oper sum not in status byte");

	property p_srq_fires;
		((stb_ff & ~$past(stb_ff) & $past(sre_ff) & ~status_pkg::SRE_IGNORE) != '0)
			|-> srq_ff;
	endproperty
	a_srq_fires: assert property (p_srq_fires) else $error("enabled rise without request");

	property p_sre_write;
		cmd.valid && cmd.write && (cmd.target == status_pkg::TGT_SRE)
			|=> sre_ff == $past(cmd.wdata[status_pkg::STB_W-1:0]);
	endproperty
	a_sre_write: assert property (p_sre_write) else $error("service enable not written");
endmodule : status_reporting_hierarchy
`default_nettype wire

// *** src/std_event_latch.sv ***
/*
 * Standard event status register with its enable mask and sum bit.
 * Assumes set_in carries one-cycle event pulses from the device core.
 */
`timescale 1ns/1ps
`default_nettype none
module std_event_latch (
	input  wire logic                          ref_clk,
	input  wire logic                          rstn,
	input  wire logic                          clear,
	input  wire logic                          sel,
	input  wire status_pkg::cmd_type           cmd,
	input  wire logic [status_pkg::ESR_W-1:0]  set_in,
	output logic      [status_pkg::REG_W-1:0]  rd_data,
	output logic                               sum_bit
);
	logic [status_pkg::ESR_W-1:0] esr_ff;
	logic [status_pkg::ESR_W-1:0] ese_ff;
	logic                         ev_rd;

	assign ev_rd = sel & cmd.valid & ~cmd.write & (cmd.part == status_pkg::PART_EVENT);

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			esr_ff <= '0;
		end else if (clear) begin
			esr_ff <= '0;
		end else begin
			esr_ff <= (esr_ff & ~{status_pkg::ESR_W{ev_rd}}) | set_in;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ese_ff <= status_pkg::ESE_RST;
		end else if (sel && cmd.valid && cmd.write && cmd.part == status_pkg::PART_MASK) begin
			ese_ff <= cmd.wdata[status_pkg::ESR_W-1:0];
		end
	end

	assign rd_data = (cmd.part == status_pkg::PART_MASK) ? {8'h00, ese_ff} : {8'h00, esr_ff};
	assign sum_bit = |(esr_ff & ese_ff);
endmodule : std_event_latch
`default_nettype wire

// *** verification/remote_ctrl_model.sv ***
/*
 * Behavioural remote controller: issues one command at a time on the
 * command port and collects the registered answer of a read.
 * Assumes the answer stands one cycle, from the taking edge itself.
 */
`timescale 1ns/1ps
`default_nettype none
module remote_ctrl_model (
	input  wire logic                ref_clk,
	input  wire status_pkg::rsp_type rsp,
	output var  status_pkg::cmd_type cmd
);
	initial cmd = '0;

	// Per-bit filter values are whatever the caller asks for
	task automatic send(
		input  logic                   wr,
		input  status_pkg::target_type tgt,
		input  status_pkg::part_type   part,
		input  logic [15:0]            wdata,
		output logic                   ok,
		output logic [15:0]            q
	);
		status_pkg::cmd_type c;
		c.valid = 1'b1;
		c.write = wr;
		c.target = tgt;
		c.part = part;
		c.wdata = wdata;
		@(posedge ref_clk);
		cmd <= c;
		@(posedge ref_clk);
		// Idle word flips data so stale values are never trusted
		c.valid = 1'b0;
		c.wdata = ~wdata;
		cmd <= c;
		#1;
		ok = wr | (rsp.valid === 1'b1);
		q = rsp.data;
	endtask : send
endmodule : remote_ctrl_model
`default_nettype wire

// *** verification/status_reporting_hierarchy_tb.sv ***
/*
 * Self-checking bench for the status reporting hierarchy: register
 * access, edge filters, clear-on-read, summaries, status byte, request.
 * Assumes the remote controller model and the design package.
 */
`timescale 1ns/1ps
`default_nettype none
module status_reporting_hierarchy_tb;
	logic                ref_clk = 1'b0;
	logic                rstn = 1'b0;
	status_pkg::cmd_type cmd;
	status_pkg::rsp_type rsp_ff;
	logic [14:0]         oper_src = '0;
	logic [14:0]         ques_src = '0;
	logic                power_status = 1'b0;
	logic [7:0]          std_events = '0;
	logic                out_buf_not_empty = 1'b0;
	status_pkg::err_type err = '0;
	logic [7:0]          stb_ff;
	logic                srq_ff;
	int                  bad_count = 0;
	int                  check_count = 0;

	always #5 ref_clk = ~ref_clk;

	remote_ctrl_model ctrl_u (.ref_clk(ref_clk), .rsp(rsp_ff), .cmd(cmd));

	status_reporting_hierarchy dut_u (
		.ref_clk(ref_clk), .rstn(rstn), .cmd(cmd), .oper_src(oper_src),
		.ques_src(ques_src), .power_status(power_status), .std_events(std_events),
		.out_buf_not_empty(out_buf_not_empty), .err(err), .rsp_ff(rsp_ff),
		.stb_ff(stb_ff), .srq_ff(srq_ff)
	);

	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic close_out();
		$display("Checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : close_out

	task automatic wr(input status_pkg::target_type t, input status_pkg::part_type p,
		input logic [15:0] d);
		logic        ok;
		logic [15:0] q;
		ctrl_u.send(1'b1, t, p, d, ok, q);
	endtask : wr

	task automatic rd(input status_pkg::target_type t, input status_pkg::part_type p,
		input logic [15:0] exp, input string what);
		logic        ok;
		logic [15:0] q;
		ctrl_u.send(1'b0, t, p, 16'h0000, ok, q);
		check({15'h0000, ok}, 16'h0001, "answer valid");
		check(q, exp, what);
	endtask : rd

	task automatic wait_n(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : wait_n

	task automatic stb_bit(input int b, input logic exp, input string what);
		check({15'h0000, stb_ff[b]}, {15'h0000, exp}, what);
	endtask : stb_bit

	initial begin
		logic found;
		repeat (3) @(posedge ref_clk);
		rstn <= 1'b1;
		wait_n(1);
		check({8'h00, stb_ff}, 16'h0000, "stb after reset");
		for (int t = 0; t < 2; t++) begin
			rd(status_pkg::target_type'(t), status_pkg::PART_RISE, 16'h7FFF, "rise rst");
			rd(status_pkg::target_type'(t), status_pkg::PART_FALL, 16'h0000, "fall rst");
			rd(status_pkg::target_type'(t), status_pkg::PART_MASK, 16'h0000, "mask rst");
			rd(status_pkg::target_type'(t), status_pkg::PART_EVENT, 16'h0000, "event rst");
		end
		rd(status_pkg::TGT_SRE, status_pkg::PART_MASK, 16'h0000, "sre rst");
		$display("Test reset done");

		wr(status_pkg::TGT_QUES, status_pkg::PART_FALL, 16'hFFFF);
		rd(status_pkg::TGT_QUES, status_pkg::PART_FALL, 16'h7FFF, "fall rw");
		rd(status_pkg::TGT_QUES, status_pkg::PART_FALL, 16'h7FFF, "fall reread");
		wr(status_pkg::TGT_OPER, status_pkg::PART_MASK, 16'hFFFF);
		rd(status_pkg::TGT_OPER, status_pkg::PART_MASK, 16'h7FFF, "mask rw");
		wr(status_pkg::TGT_OPER, status_pkg::PART_MASK, 16'h0000);
		wr(status_pkg::TGT_OPER, status_pkg::PART_COND, 16'h1234);
		rd(status_pkg::TGT_OPER, status_pkg::PART_COND, 16'h0000, "cond write");
		$display("Test access done");

		wr(status_pkg::TGT_OPER, status_pkg::PART_RISE, 16'h0001);
		wr(status_pkg::TGT_OPER, status_pkg::PART_FALL, 16'h0002);
		@(posedge ref_clk);
		oper_src <= 15'h0007;
		wait_n(3);
		rd(status_pkg::TGT_OPER, status_pkg::PART_COND, 16'h0007, "cond live");
		rd(status_pkg::TGT_OPER, status_pkg::PART_EVENT, 16'h0001, "rise only");
		rd(status_pkg::TGT_OPER, status_pkg::PART_EVENT, 16'h0000, "read clears");
		@(posedge ref_clk);
		oper_src <= 15'h0000;
		wait_n(3);
		rd(status_pkg::TGT_OPER, status_pkg::PART_EVENT, 16'h0002, "fall only");
		// Edge lands on the same edge that takes the read
		fork
			rd(status_pkg::TGT_OPER, status_pkg::PART_EVENT, 16'h0000, "old events");
			begin
				@(posedge ref_clk);
				oper_src <= 15'h0001;
			end
		join
		wait_n(2);
		rd(status_pkg::TGT_OPER, status_pkg::PART_EVENT, 16'h0001, "edge kept");
		$display("Test filters done");

		@(posedge ref_clk);
		power_status <= 1'b1;
		wait_n(3);
		stb_bit(status_pkg::STB_QUES, 1'b0, "masked sum");
		rd(status_pkg::TGT_QUES, status_pkg::PART_COND, 16'h0200, "power cond");
		wr(status_pkg::TGT_SRE, status_pkg::PART_MASK, 16'h0048);
		rd(status_pkg::TGT_SRE, status_pkg::PART_MASK, 16'h0048, "sre back");
		wr(status_pkg::TGT_QUES, status_pkg::PART_MASK, 16'h0200);
		found = 1'b0;
		for (int i = 0; i < 6; i++) begin
			wait_n(1);
			if (srq_ff === 1'b1) found = 1'b1;
		end
		check({15'h0000, found}, 16'h0001, "service request");
		if (found !== 1'b1) close_out();
		stb_bit(status_pkg::STB_QUES, 1'b1, "ques sum");
		stb_bit(status_pkg::STB_MSS, 1'b1, "master sum");
		rd(status_pkg::TGT_QUES, status_pkg::PART_EVENT, 16'h0200, "power bit");
		wait_n(3);
		stb_bit(status_pkg::STB_QUES, 1'b0, "sum drops");
		stb_bit(status_pkg::STB_MSS, 1'b0, "master drops");
		$display("Test summary done");

		@(posedge ref_clk);
		out_buf_not_empty <= 1'b1;
		wait_n(3);
		stb_bit(status_pkg::STB_MAV, 1'b1, "mav set");
		rd(status_pkg::TGT_STB, status_pkg::PART_COND, 16'h0010, "stb read");
		@(posedge ref_clk);
		out_buf_not_empty <= 1'b0;
		wait_n(3);
		stb_bit(status_pkg::STB_MAV, 1'b0, "mav clear");
		@(posedge ref_clk);
		err <= '{push: 1'b1, code: 15'h0123};
		@(posedge ref_clk);
		err <= '{push: 1'b0, code: 15'h7EDC};
		wait_n(3);
		stb_bit(status_pkg::STB_ERRQ, 1'b1, "error bit");
		rd(status_pkg::TGT_ERRQ, status_pkg::PART_EVENT, 16'h0123, "error pop");
		wait_n(3);
		stb_bit(status_pkg::STB_ERRQ, 1'b0, "queue empty");
		rd(status_pkg::TGT_ERRQ, status_pkg::PART_EVENT, 16'h0000, "empty pop");
		$display("Test buffer and queue done");

		wr(status_pkg::TGT_ESR, status_pkg::PART_MASK, 16'h0001);
		@(posedge ref_clk);
		std_events <= 8'h01;
		@(posedge ref_clk);
		std_events <= 8'h00;
		wait_n(3);
		stb_bit(status_pkg::STB_ESB, 1'b1, "esr sum");
		rd(status_pkg::TGT_ESR, status_pkg::PART_EVENT, 16'h0001, "esr read");
		wait_n(3);
		stb_bit(status_pkg::STB_ESB, 1'b0, "esr cleared");
		wr(status_pkg::TGT_OPER, status_pkg::PART_FALL, 16'h0003);
		wr(status_pkg::TGT_OPER, status_pkg::PART_MASK, 16'h0001);
		@(posedge ref_clk);
		oper_src <= 15'h0000;
		wait_n(3);
		stb_bit(status_pkg::STB_OPER, 1'b1, "oper sum");
		wr(status_pkg::TGT_CLEAR, status_pkg::PART_COND, 16'h0000);
		rd(status_pkg::TGT_OPER, status_pkg::PART_EVENT, 16'h0000, "clear events");
		stb_bit(status_pkg::STB_OPER, 1'b0, "oper cleared");
		rd(status_pkg::target_type'(3'h7), status_pkg::PART_COND, 16'h0000, "bad target");
		$display("Test clear done");
		close_out();
	end
endmodule : status_reporting_hierarchy_tb
`default_nettype wire
